/* rtl/buf_alloc.sv */
// Buffer allocator: places each socket's tx and rx buffer in the shared memory.
// Assumes sizes come from the register block; results are registered one cycle later.
module buf_alloc
    import rst_irq_pkg::*;
(
    // Clock and reset
    input wire logic   sys_clk,
    input wire logic   arst_n,
    // Sizes in, bases out
    buf_alloc_if.alloc ba
);
    // ------------------------------------------------------------------
    // Running sums
    // ------------------------------------------------------------------
    sum_t tx_acc [NUM_SOCK+1];  // Tx prefix sums
    sum_t rx_acc [NUM_SOCK+1];  // Rx prefix sums

    assign tx_acc[0] = '0;
    assign rx_acc[0] = '0;

    // Each socket starts where the one before it ends
    for (genvar g = 0; g < NUM_SOCK; g++) begin : g_sock
        assign tx_acc[g+1] = tx_acc[g] + SUM_W'(ba.tx_kb[g]);
        assign rx_acc[g+1] = rx_acc[g] + SUM_W'(ba.rx_kb[g]);
        // Register the bases
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                ba.tx_base[g] <= '0;
                ba.rx_base[g] <= '0;
            end else begin
                ba.tx_base[g] <= tx_acc[g];
                ba.rx_base[g] <= rx_acc[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // Overflow flags
    // ------------------------------------------------------------------
    logic tx_over_nxt;          // Tx total beyond memory
    logic rx_over_nxt;          // Rx total beyond memory

    // Compare each direction on its own against the memory size
    always_comb begin
        tx_over_nxt = tx_acc[NUM_SOCK] > SUM_W'(BUF_TOTAL_KB);
        rx_over_nxt = rx_acc[NUM_SOCK] > SUM_W'(BUF_TOTAL_KB);
    end

    // Register the flags
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ba.tx_over <= 1'b0;
            ba.rx_over <= 1'b0;
        end else begin
            ba.tx_over <= tx_over_nxt;
            ba.rx_over <= rx_over_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_over_flag: assert property (tx_acc[NUM_SOCK] > SUM_W'(BUF_TOTAL_KB) |=> ba.tx_over)
        else $error("tx overflow not flagged");
    cov_over: cover property (ba.tx_over || ba.rx_over);
endmodule // buf_alloc

/* rtl/buf_alloc_if.sv */
// Carrier between the register block and the buffer allocator.
// Assumes both ends run on the same sys_clk.
interface buf_alloc_if;
    import rst_irq_pkg::*;
    kb_t  tx_kb   [NUM_SOCK];   // Requested tx sizes in KB
    kb_t  rx_kb   [NUM_SOCK];   // Requested rx sizes in KB
    sum_t tx_base [NUM_SOCK];   // Tx base offsets in KB
    sum_t rx_base [NUM_SOCK];   // Rx base offsets in KB
    logic tx_over;              // Tx sum beyond the memory
    logic rx_over;              // Rx sum beyond the memory
    modport alloc (input tx_kb, rx_kb, output tx_base, rx_base, tx_over, rx_over);
    modport ctrl  (output tx_kb, rx_kb, input tx_base, rx_base, tx_over, rx_over);
endinterface

/* rtl/rst_irq_pkg.sv */
// Shared constants and types for the reset sequencer, interrupt pin and buffer allocator.
// Assumes a 50 MHz sys_clk and an AHB-Lite slave addressed by word index.
package rst_irq_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;                           // sys_clk period
    localparam int INIT_TIME_NS  = 60_300_000;                   // Initialization period after reset release
    localparam int INIT_CYC      = INIT_TIME_NS / CLK_PERIOD_NS; // Init length in cycles
    localparam int RST_MIN_NS    = 560;                          // Least reset pulse the host must give
    localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PEND_TICK_CYC = 4;                            // Cycles per pending-timer unit
    localparam int INIT_W        = 22;                           // Init counter width
    localparam int PEND_W        = 16;                           // Pending timer width

    // ------------------------------------------------------------------
    // Buffer memory
    // ------------------------------------------------------------------
    localparam int NUM_SOCK     = 4;                             // Sockets sharing the memory
    localparam int BUF_TOTAL_KB = 8;                             // Memory per direction
    localparam int KB_W         = 4;                             // Size field width in KB
    localparam int SUM_W        = 6;                             // Base and sum width in KB
    localparam logic [KB_W-1:0] DEF_BUF_KB = 4'h2;              // Reset size of every buffer
    localparam logic [7:0]      MSR_RST    = 8'h55;             // 2 KB code for all four sockets

    // ------------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_IRQ_PENDING_TIMER   = 12'h013;
    localparam logic [11:0] IDX_IR                  = 12'h015;
    localparam logic [11:0] IDX_IRQ_MASK_REG        = 12'h016;
    localparam logic [11:0] IDX_RX_SIZE_ALLOC_REG   = 12'h01a;
    localparam logic [11:0] IDX_TX_SIZE_ALLOC_REG   = 12'h01b;
    localparam logic [11:0] IDX_IR2                 = 12'h020;
    localparam logic [11:0] IDX_IRQ_MASK_REG_SECOND = 12'h021;
    localparam logic [11:0] IDX_MODE_REG_TWO        = 12'h030;
    localparam logic [11:0] IDX_SOCKETLESS_IRQ_MASK = 12'h05e;
    localparam logic [11:0] IDX_SLIR                = 12'h05f;
    localparam logic [11:0] IDX_STAT    = 12'h0f0;
    localparam logic [11:0] IDX_TXSZ    = 12'h100;              // Four per-socket tx sizes
    localparam logic [11:0] IDX_RXSZ    = 12'h104;              // Four per-socket rx sizes
    localparam logic [11:0] IDX_TXBASE  = 12'h108;              // Four tx bases, read only
    localparam logic [11:0] IDX_RXBASE  = 12'h10c;              // Four rx bases, read only

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int INT_PIN_ENABLE_BIT = 6;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_TXOV_BIT = 1;
    localparam int STAT_RXOV_BIT = 2;
    localparam logic [7:0]        REG8_RST    = 8'h00;
    localparam logic [PEND_W-1:0] PEND_TIMER_RST = 16'h0000;

    typedef logic [KB_W-1:0]  kb_t;
    typedef logic [SUM_W-1:0] sum_t;
    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN  = 2'b10
    } seq_state_t;
endpackage

/* rtl/rst_irq_top.sv */
// Reset sequencer, interrupt pin control and buffer size registers behind AHB-Lite.
// Assumes arst_n is the board reset pin and all other inputs are synchronous to sys_clk.
module rst_irq_top
    import rst_irq_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,       // Initialization length in cycles
    parameter int TICK_CYCLES = PEND_TICK_CYC   // Cycles per pending-time unit
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Interrupt events, one-cycle pulses
    input  wire logic [7:0]        ir_evt,
    input  wire logic [7:0]        ir2_evt,
    input  wire logic [7:0]        sl_evt,
    // Device outputs
    output logic                   irq_out_low,
    output logic                   init_done
);
    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    seq_state_t        state_r;         // Init or run
    seq_state_t        state_nxt;
    logic [INIT_W-1:0] init_cnt_r;      // Cycles spent initializing
    logic [INIT_W-1:0] init_cnt_nxt;
    logic              run;             // Normal operation

    // Count out the init period, then run until the next reset
    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        case (state_r)
            ST_INIT: begin
                if (init_cnt_r == INIT_W'(INIT_CYCLES - 1)) begin
                    state_nxt = ST_RUN;
                end else begin
                    init_cnt_nxt = init_cnt_r + 1'b1;
                end
            end
            ST_RUN:  state_nxt = ST_RUN;
            default: state_nxt = ST_INIT;
        endcase
    end

    // Reset forces the init state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= ST_INIT;
            init_cnt_r <= '0;
            init_done  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            init_done  <= (state_nxt == ST_RUN);
        end
    end

    assign run = (state_r == ST_RUN);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        take;                  // Address phase accepted
    logic [11:0] a_idx;                 // Word index of the address phase
    logic        wr_pend_r;             // Write data phase in progress
    logic [11:0] wr_idx_r;              // Index of the pending write
    logic        wr_en;                 // Write lands this cycle
    logic [31:0] rd_val;                // Read mux output

    assign take  = hsel && hready && htrans[1];
    assign a_idx = haddr[ADDR_W-1:2];
    assign wr_en = wr_pend_r && run;    // Writes during init are dropped

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]        mode_reg_two_r, mode_reg_two_nxt;                 // Mode register two
    logic [PEND_W-1:0] ptm_r, ptm_nxt;                                   // Pending time setting
    logic [7:0]        ir_r, ir_nxt;                                     // Common interrupt status
    logic [7:0]        irq_mask_reg_r, irq_mask_reg_nxt;                 // Common interrupt mask
    logic [7:0]        ir2_r, ir2_nxt;                                   // Second interrupt status
    logic [7:0]        irq_mask_reg_second_r, irq_mask_reg_second_nxt;   // Second interrupt mask
    logic [7:0]        slir_r, slir_nxt;                                 // Socketless interrupt status
    logic [7:0]        socketless_irq_mask_r, socketless_irq_mask_nxt;   // Socketless interrupt mask
    logic [7:0]        tx_size_alloc_reg_r, tx_size_alloc_reg_nxt;       // Common tx size codes
    logic [7:0]        rx_size_alloc_reg_r, rx_size_alloc_reg_nxt;       // Common rx size codes
    kb_t               txkb_nxt [NUM_SOCK];     // Next tx sizes
    kb_t               rxkb_nxt [NUM_SOCK];     // Next rx sizes

    buf_alloc_if ba ();

    // Two-bit size code to KB: 1, 2, 4 or 8
    function automatic kb_t code_kb(input logic [1:0] code);
        code_kb = kb_t'(4'h1 << code);
    endfunction

    // Next register values: bus writes, then hardware sets
    always_comb begin
        mode_reg_two_nxt        = mode_reg_two_r;
        ptm_nxt                 = ptm_r;
        ir_nxt                  = ir_r;
        irq_mask_reg_nxt        = irq_mask_reg_r;
        ir2_nxt                 = ir2_r;
        irq_mask_reg_second_nxt = irq_mask_reg_second_r;
        slir_nxt                = slir_r;
        socketless_irq_mask_nxt = socketless_irq_mask_r;
        tx_size_alloc_reg_nxt   = tx_size_alloc_reg_r;
        rx_size_alloc_reg_nxt   = rx_size_alloc_reg_r;
        txkb_nxt  = ba.tx_kb;
        rxkb_nxt  = ba.rx_kb;
        if (wr_en) begin
            case (wr_idx_r)
                IDX_MODE_REG_TWO:        mode_reg_two_nxt        = hwdata[7:0];
                IDX_IRQ_PENDING_TIMER:   ptm_nxt                 = hwdata[PEND_W-1:0];
                IDX_IR:                  ir_nxt                  = ir_r & ~hwdata[7:0]; // Write one to clear
                IDX_IRQ_MASK_REG:        irq_mask_reg_nxt        = hwdata[7:0];
                IDX_IR2:                 ir2_nxt                 = ir2_r & ~hwdata[7:0];
                IDX_IRQ_MASK_REG_SECOND: irq_mask_reg_second_nxt = hwdata[7:0];
                IDX_SLIR:                slir_nxt                = slir_r & ~hwdata[7:0];
                IDX_SOCKETLESS_IRQ_MASK: socketless_irq_mask_nxt = hwdata[7:0];
                IDX_TX_SIZE_ALLOC_REG: begin
                    tx_size_alloc_reg_nxt = hwdata[7:0];
                    for (int s = 0; s < NUM_SOCK; s++) begin
                        txkb_nxt[s] = code_kb(hwdata[2*s +: 2]);
                    end
                end
                IDX_RX_SIZE_ALLOC_REG: begin
                    rx_size_alloc_reg_nxt = hwdata[7:0];
                    for (int s = 0; s < NUM_SOCK; s++) begin
                        rxkb_nxt[s] = code_kb(hwdata[2*s +: 2]);
                    end
                end
                default: begin
                    // Per-socket size writes
                    if (wr_idx_r[11:2] == IDX_TXSZ[11:2]) begin
                        txkb_nxt[wr_idx_r[1:0]] = hwdata[KB_W-1:0];
                    end
                    if (wr_idx_r[11:2] == IDX_RXSZ[11:2]) begin
                        rxkb_nxt[wr_idx_r[1:0]] = hwdata[KB_W-1:0];
                    end
                end
            endcase
        end
        // A set in the same cycle as a clear wins
        if (run) begin
            ir_nxt   = ir_nxt | ir_evt;
            ir2_nxt  = ir2_nxt | ir2_evt;
            slir_nxt = slir_nxt | sl_evt;
        end
    end

    // Register the configuration and status
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg_two_r        <= REG8_RST;
            ptm_r                 <= PEND_TIMER_RST;
            ir_r                  <= REG8_RST;
            irq_mask_reg_r        <= REG8_RST;
            ir2_r                 <= REG8_RST;
            irq_mask_reg_second_r <= REG8_RST;
            slir_r                <= REG8_RST;
            socketless_irq_mask_r <= REG8_RST;
            tx_size_alloc_reg_r   <= MSR_RST;
            rx_size_alloc_reg_r   <= MSR_RST;
            for (int s = 0; s < NUM_SOCK; s++) begin
                ba.tx_kb[s] <= DEF_BUF_KB;
                ba.rx_kb[s] <= DEF_BUF_KB;
            end
        end else begin
            mode_reg_two_r        <= mode_reg_two_nxt;
            ptm_r                 <= ptm_nxt;
            ir_r                  <= ir_nxt;
            irq_mask_reg_r        <= irq_mask_reg_nxt;
            ir2_r                 <= ir2_nxt;
            irq_mask_reg_second_r <= irq_mask_reg_second_nxt;
            slir_r                <= slir_nxt;
            socketless_irq_mask_r <= socketless_irq_mask_nxt;
            tx_size_alloc_reg_r   <= tx_size_alloc_reg_nxt;
            rx_size_alloc_reg_r   <= rx_size_alloc_reg_nxt;
            ba.tx_kb <= txkb_nxt;
            ba.rx_kb <= rxkb_nxt;
        end
    end

    buf_alloc u_alloc (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .ba      (ba)
    );

    // Read mux on the address-phase index; unmapped reads give zero
    always_comb begin
        rd_val = 32'h0000_0000;
        case (a_idx)
            IDX_MODE_REG_TWO:        rd_val[7:0]        = mode_reg_two_r;
            IDX_IRQ_PENDING_TIMER:   rd_val[PEND_W-1:0] = ptm_r;
            IDX_IR:                  rd_val[7:0]        = ir_r;
            IDX_IRQ_MASK_REG:        rd_val[7:0]        = irq_mask_reg_r;
            IDX_IR2:                 rd_val[7:0]        = ir2_r;
            IDX_IRQ_MASK_REG_SECOND: rd_val[7:0]        = irq_mask_reg_second_r;
            IDX_SLIR:                rd_val[7:0]        = slir_r;
            IDX_SOCKETLESS_IRQ_MASK: rd_val[7:0]        = socketless_irq_mask_r;
            IDX_TX_SIZE_ALLOC_REG:   rd_val[7:0]        = tx_size_alloc_reg_r;
            IDX_RX_SIZE_ALLOC_REG:   rd_val[7:0]        = rx_size_alloc_reg_r;
            IDX_STAT: begin
                rd_val[STAT_INIT_BIT] = init_done;
                rd_val[STAT_TXOV_BIT] = ba.tx_over;
                rd_val[STAT_RXOV_BIT] = ba.rx_over;
            end
            default: begin
                case (a_idx[11:2])
                    IDX_TXSZ[11:2]:   rd_val[KB_W-1:0]  = ba.tx_kb[a_idx[1:0]];
                    IDX_RXSZ[11:2]:   rd_val[KB_W-1:0]  = ba.rx_kb[a_idx[1:0]];
                    IDX_TXBASE[11:2]: rd_val[SUM_W-1:0] = ba.tx_base[a_idx[1:0]];
                    IDX_RXBASE[11:2]: rd_val[SUM_W-1:0] = ba.rx_base[a_idx[1:0]];
                    default:          rd_val            = 32'h0000_0000;
                endcase
            end
        endcase
    end

    // Zero-wait slave: read data registered into the data phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= take && hwrite;
            if (take) begin
                wr_idx_r <= a_idx;
            end
            if (take && !hwrite) begin
                hrdata <= rd_val;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    logic              pend_any;                // Unmasked event pending
    logic              int_pin_enable;          // Pin enable
    logic [PEND_W-1:0] wait_r, wait_nxt;        // Pending-time hold-off
    logic [7:0]        tick_cnt_r, tick_cnt_nxt; // Tick divider
    logic              tick;                    // One-cycle timer unit pulse
    logic              irq_nxt;

    assign pend_any       = |(ir_r & irq_mask_reg_r) || |(ir2_r & irq_mask_reg_second_r)
                            || |(slir_r & socketless_irq_mask_r);
    assign int_pin_enable = mode_reg_two_r[INT_PIN_ENABLE_BIT];
    assign tick     = (tick_cnt_r == 8'(TICK_CYCLES - 1));

    // Pin low only when running, enabled, unmasked pending and hold-off done
    always_comb begin
        tick_cnt_nxt = tick ? 8'h00 : tick_cnt_r + 8'h01;
        irq_nxt      = !(run && int_pin_enable && pend_any && wait_r == '0);
        wait_nxt     = wait_r;
        if (!irq_out_low && irq_nxt) begin
            wait_nxt = ptm_r;
        end else if (tick && wait_r != '0) begin
            wait_nxt = wait_r - 1'b1;
        end
    end

    // Register pin and timers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_out_low <= 1'b1;
            wait_r      <= '0;
            tick_cnt_r  <= 8'h00;
        end else begin
            irq_out_low <= irq_nxt;
            wait_r      <= wait_nxt;
            tick_cnt_r  <= tick_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_irq_init_high: assert property (!run |=> irq_out_low)
        else $error("irq pin low during init");
    chk_irq_low_cause: assert property (!irq_out_low |-> $past(pend_any && int_pin_enable && run))
        else $error("irq pin low without cause");
    chk_irq_masked: assert property (!(pend_any && int_pin_enable) |=> irq_out_low)
        else $error("irq pin low while masked or disabled");
    chk_irq_assert: assert property (run && int_pin_enable && pend_any && wait_r == '0 |=> !irq_out_low)
        else $error("irq pin not asserted");
    chk_irq_holdoff: assert property ($rose(irq_out_low) |-> wait_r == $past(ptm_r))
        else $error("pending time not loaded");
    chk_init_len: assert property (state_r == ST_INIT && init_cnt_r == INIT_W'(INIT_CYCLES - 1)
                                   |=> state_r == ST_RUN && init_done)
        else $error("init period wrong");
    chk_init_state: assert property (state_r == ST_INIT |-> !init_done && init_cnt_r < INIT_W'(INIT_CYCLES))
        else $error("init state inconsistent");
    chk_default_size: assert property (!run |-> ba.tx_kb[0] == DEF_BUF_KB && ba.rx_kb[3] == DEF_BUF_KB)
        else $error("default sizes lost during init");
    chk_tx_alloc_apply: assert property (wr_en && wr_idx_r == IDX_TX_SIZE_ALLOC_REG
                                         |=> ba.tx_kb[1] == code_kb($past(hwdata[3:2])))
        else $error("common tx size not applied");
    chk_set_wins: assert property (run && ir_evt[0] |=> ir_r[0])
        else $error("interrupt event lost");

    cov_irq_low: cover property ($fell(irq_out_low));
    cov_run: cover property ($rose(init_done));
    cov_tx_alloc: cover property (wr_en && wr_idx_r == IDX_TX_SIZE_ALLOC_REG);
endmodule // rst_irq_top

/* tb/host_rst_model.sv */
// Host model: drives the device reset pin on request.
// Assumes requests are synchronous to sys_clk.
module host_rst_model
    import rst_irq_pkg::*;
(
    // Clock and request
    input  wire logic sys_clk,
    input  wire logic rst_req,
    // Reset pin toward the device
    output logic      arst_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial arst_n = 1'b0;
    int unsigned low_cnt = 0; // Cycles the pin has been low
    // Stretch any request past the least pulse width, then release
    always @(posedge sys_clk) begin
        if (rst_req) begin
            arst_n  <= 1'b0;
            low_cnt <= 0;
        end else if (low_cnt <= RST_MIN_CYC) begin
            low_cnt <= low_cnt + 1;
        end else begin
            arst_n <= 1'b1;
        end
    end
endmodule // host_rst_model

/* tb/rst_irq_top_tb.sv */
// Testbench: AHB-Lite register tasks, event pulses and the host reset model.
// Assumes a zero-wait slave and a shortened initialization.
module rst_irq_top_tb
    import rst_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT_N = 20; // Shortened init length
    logic              sys_clk, arst_n, rst_req, hsel, hwrite, hreadyout, hresp, irq_out_low, init_done;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic [31:0]       hwdata, hrdata, rd_v;
    logic [23:0]       evt; // Socketless, second and common events
    logic [11:0]       mask_idx [3] = '{IDX_IRQ_MASK_REG, IDX_IRQ_MASK_REG_SECOND, IDX_SOCKETLESS_IRQ_MASK};
    logic [11:0]       stat_idx [3] = '{IDX_IR, IDX_IR2, IDX_SLIR};
    int                errors = 0, samples_checked = 0, cyc = 0;
    rst_irq_top #(.INIT_CYCLES(INIT_N), .TICK_CYCLES(PEND_TICK_CYC)) rst_irq_top_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ir_evt(evt[7:0]), .ir2_evt(evt[15:8]), .sl_evt(evt[23:16]),
        .irq_out_low(irq_out_low), .init_done(init_done));
    host_rst_model host_rst_model_inst (.sys_clk(sys_clk), .rst_req(rst_req), .arst_n(arst_n));
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single AHB transfer; read data lands in rd_v
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {idx, 2'b00};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd_v = hrdata;
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input string name);
        xfer(1'b0, idx, 32'h0);
        check(name, rd_v, exp);
    endtask
    // One-cycle event, then time for the pin to follow
    task automatic pulse(input int n);
        evt[n] <= 1'b1;
        @(posedge sys_clk);
        evt <= '0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        {rst_req, hsel, htrans, hwrite, haddr, hwdata, evt} = '0;
        rst_req = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst_req <= 1'b0;
        wait (arst_n === 1'b1);
        @(posedge sys_clk);
        // Writes and events during init are dropped
        xfer(1'b1, IDX_MODE_REG_TWO, 32'h40);
        pulse(0);
        check("init_busy", init_done, 1'b0);
        check("irq_init", irq_out_low, 1'b1);
        while (init_done !== 1'b1) @(posedge sys_clk);
        rd(IDX_MODE_REG_TWO, 32'h0, "mode_init");
        rd(IDX_IR, 32'h0, "ir_init");
        // Default and programmed buffer placement
        rd(IDX_TX_SIZE_ALLOC_REG, 32'h55, "tx_alloc_rst");
        rd(IDX_RX_SIZE_ALLOC_REG, 32'h55, "rx_alloc_rst");
        rd(IDX_TXBASE + 12'h3, 32'h6, "txbase3");
        // Bases follow the sizes one cycle later, so let one edge pass
        xfer(1'b1, IDX_TX_SIZE_ALLOC_REG, 32'h1b);
        @(posedge sys_clk);
        rd(IDX_TXBASE + 12'h3, 32'he, "txbase3_prog");
        rd(IDX_STAT, 32'h3, "stat_over");
        // Sizes that fill the memory exactly stay within the limit
        xfer(1'b1, IDX_TX_SIZE_ALLOC_REG, 32'h06);
        @(posedge sys_clk);
        rd(IDX_TXBASE + 12'h3, 32'h7, "txbase3_full");
        rd(IDX_STAT, 32'h1, "stat_full");
        xfer(1'b1, IDX_RXSZ, 32'h1);
        @(posedge sys_clk);
        rd(IDX_RXBASE + 12'h1, 32'h1, "rxbase1");
        // Each event source through its mask and the pin enable
        for (int g = 0; g < 3; g++) begin
            xfer(1'b1, mask_idx[g], 32'h1 << (2 * g + 1));
            pulse(10 * g + 1);
            check("irq_gated", irq_out_low, 32'(g == 0));
            if (g == 0) begin
                xfer(1'b1, IDX_MODE_REG_TWO, 32'h40);
                repeat (3) @(posedge sys_clk);
            end
            check("irq_set", irq_out_low, 1'b0);
            rd(stat_idx[g], 32'h1 << (2 * g + 1), "status");
            xfer(1'b1, mask_idx[g], 32'h0);
            repeat (2) @(posedge sys_clk);
            check("irq_masked", irq_out_low, 1'b1);
            xfer(1'b1, stat_idx[g], 32'h1 << (2 * g + 1));
            rd(stat_idx[g], 32'h0, "status_clr");
        end
        // Pending time holds the pin off after a release
        xfer(1'b1, IDX_IRQ_PENDING_TIMER, 32'h3);
        xfer(1'b1, IDX_IRQ_MASK_REG, 32'h1);
        pulse(0);
        check("irq_hold_set", irq_out_low, 1'b0);
        xfer(1'b1, IDX_IR, 32'h1);
        pulse(0);
        check("irq_holdoff", irq_out_low, 1'b1);
        repeat (16) @(posedge sys_clk);
        check("irq_hold_end", irq_out_low, 1'b0);
        // Reset in mid-run returns everything to defaults
        rst_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst_req <= 1'b0;
        check("rst_done", init_done, 1'b0);
        wait (arst_n === 1'b1);
        @(posedge sys_clk);
        check("irq_rerst", irq_out_low, 1'b1);
        rd(IDX_TX_SIZE_ALLOC_REG, 32'h55, "tx_alloc_rerst");
        rd(IDX_MODE_REG_TWO, 32'h0, "mode_rerst");
        close_out();
    end
endmodule // rst_irq_top_tb
